/* File: rtl/sfu_fifo.sv */
`timescale 1ns/1ps
module sfu_fifo #(
    parameter int WIDTH = 8,
    parameter int DEPTH = 16
) (
    // Clock, reset and flush.
    input wire logic clk,
    input wire logic rstB,
    input wire logic flush,
    // Fill side.
    input wire logic inValid,
    output logic inReady,
    input wire logic [WIDTH-1:0] inData,
    // Drain side.
    input wire logic outReady,
    output logic outValid,
    output logic [WIDTH-1:0] outData
);

    localparam int PTR_BITS = $clog2(DEPTH);

    typedef struct packed {
        logic [DEPTH-1:0][WIDTH-1:0] mem;
        logic [PTR_BITS-1:0] wrPtr;
        logic [PTR_BITS-1:0] rdPtr;
        logic [PTR_BITS:0] count;
    } sfu_fifo_type;

    localparam logic [PTR_BITS:0] FULL_COUNT = (PTR_BITS + 1)'(DEPTH);
    localparam logic [PTR_BITS-1:0] LAST_PTR = PTR_BITS'(DEPTH - 1);

    sfu_fifo_type cur_ff;
    sfu_fifo_type nxt_cur;
    logic push;
    logic pop;

    function automatic logic [PTR_BITS-1:0] ptrNext(input logic [PTR_BITS-1:0] ptr);
        ptrNext = (ptr == LAST_PTR) ? '0 : ptr + 1'b1;
    endfunction

    always_comb begin
        nxt_cur = cur_ff;
        push = inValid && (cur_ff.count != FULL_COUNT);
        pop = outReady && (cur_ff.count != '0);
        if (push) begin
            nxt_cur.mem[cur_ff.wrPtr] = inData;
            nxt_cur.wrPtr = ptrNext(cur_ff.wrPtr);
        end
        if (pop) begin
            nxt_cur.rdPtr = ptrNext(cur_ff.rdPtr);
        end
        if (push && !pop) begin
            nxt_cur.count = cur_ff.count + 1'b1;
        end else if (pop && !push) begin
            nxt_cur.count = cur_ff.count - 1'b1;
        end
        if (flush) begin
            nxt_cur.wrPtr = '0;
            nxt_cur.rdPtr = '0;
            nxt_cur.count = '0;
        end
    end

    always_ff @(posedge clk or negedge rstB) begin
        if (!rstB) begin
            cur_ff <= '0;
        end else begin
            cur_ff <= nxt_cur;
        end
    end

    assign inReady = (cur_ff.count != FULL_COUNT);
    assign outValid = (cur_ff.count != '0);
    assign outData = cur_ff.mem[cur_ff.rdPtr];

endmodule

/* File: rtl/sfu_pkg.sv */
package sfu_pkg;

    // ----------------------------------------------------------------
    // Widths and counts
    // ----------------------------------------------------------------
    localparam int BYTE_BITS = 8;
    localparam int ADDR_BITS = 24;
    localparam int CNT_BITS = 5;
    localparam int BIT_IDX_BITS = 3;
    localparam int REG_SEL_BITS = 2;
    localparam int UID_BITS = 128;
    localparam int UID_BYTES = UID_BITS / BYTE_BITS;
    localparam int UID_IDX_BITS = 4;
    localparam int FIFO_DEPTH = 16;

    // ----------------------------------------------------------------
    // Address fields
    // ----------------------------------------------------------------
    localparam int ADDR_HIGH_LSB = 16;
    localparam int ADDR_PAGE_LSB = 8;

    // ----------------------------------------------------------------
    // Opcodes, pages and fixed values
    // ----------------------------------------------------------------
    localparam logic [BYTE_BITS-1:0] OPC_SECREG_READ = 8'h48;
    localparam logic [BYTE_BITS-1:0] OPC_UID_READ = 8'h4B;
    localparam logic [BYTE_BITS-1:0] SECREG_PAGE1 = 8'h11;
    localparam logic [BYTE_BITS-1:0] SECREG_PAGE2 = 8'h21;
    localparam logic [BYTE_BITS-1:0] SECREG_PAGE3 = 8'h31;
    localparam logic [BYTE_BITS-1:0] ADDR_HIGH_ZERO = 8'h00;
    localparam logic [BYTE_BITS-1:0] UNDEF_BYTE = 8'hFF;
    localparam logic [REG_SEL_BITS-1:0] REG_NONE = 2'h0;
    localparam logic [REG_SEL_BITS-1:0] REG_ONE = 2'h1;
    localparam logic [REG_SEL_BITS-1:0] REG_TWO = 2'h2;
    localparam logic [REG_SEL_BITS-1:0] REG_THREE = 2'h3;

    // Identifier value is arbitrary.
    localparam logic [UID_BITS-1:0] UID_DEFAULT = 128'h0123_4567_89AB_CDEF_FEDC_BA98_7654_3210;

    // ----------------------------------------------------------------
    // Bit counter end points
    // ----------------------------------------------------------------
    localparam logic [CNT_BITS-1:0] CNT_ZERO = 5'h00;
    localparam logic [CNT_BITS-1:0] OPC_LAST = 5'h07;
    localparam logic [CNT_BITS-1:0] ADDR_LAST = 5'h17;
    localparam logic [CNT_BITS-1:0] DUMMY_LAST = 5'h07;
    localparam logic [BIT_IDX_BITS-1:0] BIT_MSB = 3'h7;
    localparam logic [BIT_IDX_BITS-1:0] BIT_LSB = 3'h0;

    // ----------------------------------------------------------------
    // Types
    // ----------------------------------------------------------------
    typedef enum logic [2:0] {
        LNK_OPCODE, LNK_ADDR, LNK_DUMMY, LNK_DATA, LNK_IGNORE
    } sfu_link_state_type;

    typedef enum logic {SYS_IDLE, SYS_FILL} sfu_sys_state_type;

    // Maps an address to security register one to three, or none.
    function automatic logic [REG_SEL_BITS-1:0] secregSelect(input logic [ADDR_BITS-1:0] addr);
        logic [BYTE_BITS-1:0] high;
        logic [BYTE_BITS-1:0] page;
        high = addr[ADDR_HIGH_LSB +: BYTE_BITS];
        page = addr[ADDR_PAGE_LSB +: BYTE_BITS];
        secregSelect = REG_NONE;
        if (high == ADDR_HIGH_ZERO) begin
            if (page == SECREG_PAGE1) secregSelect = REG_ONE;
            if (page == SECREG_PAGE2) secregSelect = REG_TWO;
            if (page == SECREG_PAGE3) secregSelect = REG_THREE;
        end
    endfunction

endpackage

/* File: rtl/sfu_secreg_uid_read.sv */
`timescale 1ns/1ps
module sfu_secreg_uid_read
    import sfu_pkg::*;
#(
    parameter logic [sfu_pkg::UID_BITS-1:0] UID_VALUE = sfu_pkg::UID_DEFAULT,
    parameter int FIFO_WORDS = sfu_pkg::FIFO_DEPTH
) (
    // System clock and reset.
    input wire logic clk_sys,
    input wire logic rst_b,
    // Serial link pins.
    input wire logic serialClk,
    input wire logic chipSelN,
    input wire logic serialInLine,
    output logic serialOutData,
    output logic serialOutEn,
    // Security register array read port, data one cycle after the strobe.
    output logic arrRdEn,
    output logic [sfu_pkg::REG_SEL_BITS-1:0] arrRdReg,
    output logic [sfu_pkg::BYTE_BITS-1:0] arrRdOffset,
    input wire logic [sfu_pkg::BYTE_BITS-1:0] arrRdData
);

    import sfu_pkg::*;

    // ----------------------------------------------------------------
    // State types
    // ----------------------------------------------------------------
    typedef struct packed {
        sfu_link_state_type state;
        logic [CNT_BITS-1:0] bitCnt;
        logic [ADDR_BITS-1:0] shiftIn;
        logic isUid;
        logic startReq;
        logic reqTgl;
        logic [BIT_IDX_BITS-1:0] bitIdx;
        logic [BYTE_BITS-1:0] curByte;
    } sfu_link_type;

    typedef struct packed {
        logic soData;
        logic soEn;
    } sfu_out_type;

    typedef struct packed {
        sfu_sys_state_type state;
        logic isUid;
        logic [REG_SEL_BITS-1:0] regSel;
        logic [BYTE_BITS-1:0] offset;
        logic [UID_IDX_BITS-1:0] uidIdx;
        logic rdPend;
        logic rdFromArr;
        logic [BYTE_BITS-1:0] rdByte;
        logic startSeen;
        logic reqSeen;
        logic pendPop;
        logic popAck;
        logic [BYTE_BITS-1:0] holdData;
        logic arrRdEn;
        logic [REG_SEL_BITS-1:0] arrRdReg;
        logic [BYTE_BITS-1:0] arrRdOffset;
    } sfu_sys_type;

    // ----------------------------------------------------------------
    // Link domain reset
    // ----------------------------------------------------------------
    // Deselect holds the whole link side in reset, so a frame that is
    // cut short leaves nothing behind for the next one.
    logic linkRstB;

    assign linkRstB = rst_b && !chipSelN;

    // ----------------------------------------------------------------
    // Link domain: command, address and dummy capture
    // ----------------------------------------------------------------
    sfu_link_type link_ff;
    sfu_link_type nxt_link;
    sfu_sys_type sys_ff;
    logic ackSync;
    logic ackMatch;
    logic [BYTE_BITS-1:0] opcodeIn;
    logic [BYTE_BITS-1:0] nextByte;

    // The acknowledge toggle only tells the link that holdData is stable.
    sfu_sync #(
        .WIDTH(1)
    ) u_ack_sync (
        .clk(serialClk),
        .rstB(linkRstB),
        .asyncIn(sys_ff.popAck),
        .syncOut(ackSync)
    );

    always_comb begin
        nxt_link = link_ff;
        opcodeIn = {link_ff.shiftIn[BYTE_BITS-2:0], serialInLine};
        ackMatch = (ackSync == link_ff.reqTgl);
        nextByte = ackMatch ? sys_ff.holdData : UNDEF_BYTE;
        unique case (link_ff.state)
            LNK_OPCODE: begin
                nxt_link.shiftIn = {link_ff.shiftIn[ADDR_BITS-2:0], serialInLine};
                nxt_link.bitCnt = link_ff.bitCnt + 1'b1;
                if (link_ff.bitCnt == OPC_LAST) begin
                    nxt_link.bitCnt = CNT_ZERO;
                    if (opcodeIn == OPC_SECREG_READ) begin
                        nxt_link.state = LNK_ADDR;
                        nxt_link.isUid = 1'b0;
                    end else if (opcodeIn == OPC_UID_READ) begin
                        nxt_link.state = LNK_ADDR;
                        nxt_link.isUid = 1'b1;
                    end else begin
                        nxt_link.state = LNK_IGNORE;
                    end
                end
            end
            LNK_ADDR: begin
                nxt_link.shiftIn = {link_ff.shiftIn[ADDR_BITS-2:0], serialInLine};
                nxt_link.bitCnt = link_ff.bitCnt + 1'b1;
                if (link_ff.bitCnt == ADDR_LAST) begin
                    // Address word is now stable until deselect; announce it and
                    // ask for the first byte during the dummy clocks.
                    nxt_link.bitCnt = CNT_ZERO;
                    nxt_link.startReq = 1'b1;
                    nxt_link.reqTgl = !link_ff.reqTgl;
                    nxt_link.state = LNK_DUMMY;
                end
            end
            LNK_DUMMY: begin
                nxt_link.bitCnt = link_ff.bitCnt + 1'b1;
                if (link_ff.bitCnt == DUMMY_LAST) begin
                    nxt_link.bitCnt = CNT_ZERO;
                    nxt_link.state = LNK_DATA;
                    nxt_link.curByte = nextByte;
                    nxt_link.bitIdx = BIT_MSB;
                    nxt_link.reqTgl = !link_ff.reqTgl;
                end
            end
            LNK_DATA: begin
                if (link_ff.bitIdx == BIT_LSB) begin
                    nxt_link.curByte = nextByte;
                    nxt_link.bitIdx = BIT_MSB;
                    nxt_link.reqTgl = !link_ff.reqTgl;
                end else begin
                    nxt_link.bitIdx = link_ff.bitIdx - 1'b1;
                end
            end
            LNK_IGNORE: begin
                // An unknown opcode parks the link here until deselect.
                nxt_link = link_ff;
            end
        endcase
    end

    always_ff @(posedge serialClk or negedge linkRstB) begin
        if (!linkRstB) begin
            link_ff <= '{state: LNK_OPCODE, default: '0};
        end else begin
            link_ff <= nxt_link;
        end
    end

    // ----------------------------------------------------------------
    // Link domain: output stage on the falling edge
    // ----------------------------------------------------------------
    sfu_out_type out_ff;
    sfu_out_type nxt_out;

    // Data changes on the falling edge, so it is settled at the host's rising edge.
    // Before the data phase the byte register holds zero, so the data pin rests low.
    always_comb begin
        nxt_out.soEn = (link_ff.state == LNK_DATA);
        nxt_out.soData = link_ff.curByte[link_ff.bitIdx];
    end

    always_ff @(negedge serialClk or negedge linkRstB) begin
        if (!linkRstB) begin
            out_ff <= '0;
        end else begin
            out_ff <= nxt_out;
        end
    end

    assign serialOutData = out_ff.soData;
    assign serialOutEn = out_ff.soEn;

    // ----------------------------------------------------------------
    // System domain: synchronisers
    // ----------------------------------------------------------------
    // Chip select and the two link flags enter the system clock here.
    // Each bit is a level or a toggle, so bits may land a cycle apart.
    logic deselSync;
    logic startSync;
    logic reqSync;

    sfu_sync #(
        .WIDTH(3)
    ) u_sys_sync (
        .clk(clk_sys),
        .rstB(rst_b),
        .asyncIn({chipSelN, link_ff.startReq, link_ff.reqTgl}),
        .syncOut({deselSync, startSync, reqSync})
    );

    // ----------------------------------------------------------------
    // System domain: prefetch buffer
    // ----------------------------------------------------------------
    logic fifoInReady;
    logic fifoOutValid;
    logic fifoOutReady;
    logic [BYTE_BITS-1:0] fifoInData;
    logic [BYTE_BITS-1:0] fifoOutData;

    // Prefetched bytes wait here until the link asks for them.
    // Deselect flushes the buffer, so a new frame never sees stale bytes.
    sfu_fifo #(
        .WIDTH(BYTE_BITS),
        .DEPTH(FIFO_WORDS)
    ) u_fifo (
        .clk(clk_sys),
        .rstB(rst_b),
        .flush(deselSync),
        .inValid(sys_ff.rdPend),
        .inReady(fifoInReady),
        .inData(fifoInData),
        .outReady(fifoOutReady),
        .outValid(fifoOutValid),
        .outData(fifoOutData)
    );

    assign fifoInData = sys_ff.rdFromArr ? arrRdData : sys_ff.rdByte;

    // ----------------------------------------------------------------
    // System domain: fetch and hand-over
    // ----------------------------------------------------------------
    sfu_sys_type nxt_sys;
    logic startRise;
    logic popWanted;
    logic [ADDR_BITS-1:0] reqAddr;

    // Returns identifier byte idx, counted from the most significant byte.
    function automatic logic [BYTE_BITS-1:0] uidByte(input logic [UID_IDX_BITS-1:0] idx);
        logic [UID_IDX_BITS-1:0] fromTop;
        fromTop = UID_IDX_BITS'(UID_BYTES - 1) - idx;
        uidByte = UID_VALUE[fromTop * BYTE_BITS +: BYTE_BITS];
    endfunction

    always_comb begin
        nxt_sys = sys_ff;
        nxt_sys.arrRdEn = 1'b0;
        nxt_sys.rdPend = 1'b0;
        reqAddr = link_ff.shiftIn;
        startRise = startSync && !sys_ff.startSeen;
        popWanted = sys_ff.pendPop || (reqSync != sys_ff.reqSeen);
        fifoOutReady = 1'b0;
        nxt_sys.startSeen = startSync;
        nxt_sys.reqSeen = reqSync;
        if (startRise) begin
            // The link holds the address until deselect, so it is read here
            // only after the synchronised start level has been seen.
            nxt_sys.state = SYS_FILL;
            nxt_sys.isUid = link_ff.isUid;
            nxt_sys.regSel = secregSelect(reqAddr);
            nxt_sys.offset = reqAddr[BYTE_BITS-1:0];
            nxt_sys.uidIdx = '0;
        end else if (sys_ff.state == SYS_FILL && fifoInReady && !sys_ff.rdPend
                && !sys_ff.arrRdEn) begin
            // Only one byte is ever in flight towards the buffer.
            nxt_sys.rdFromArr = 1'b0;
            if (sys_ff.isUid) begin
                nxt_sys.rdPend = 1'b1;
                nxt_sys.rdByte = uidByte(sys_ff.uidIdx);
                nxt_sys.uidIdx = sys_ff.uidIdx + 1'b1;
            end else if (sys_ff.regSel != REG_NONE) begin
                // The array answers one cycle after the strobe, so the push
                // into the buffer waits for that cycle.
                nxt_sys.rdFromArr = 1'b1;
                nxt_sys.arrRdEn = 1'b1;
                nxt_sys.arrRdReg = sys_ff.regSel;
                nxt_sys.arrRdOffset = sys_ff.offset;
                nxt_sys.offset = sys_ff.offset + 1'b1;
            end else begin
                nxt_sys.rdPend = 1'b1;
                nxt_sys.rdByte = UNDEF_BYTE;
            end
        end

        // Array data stands only in the cycle after the strobe; push it then.
        if (sys_ff.arrRdEn) begin
            nxt_sys.rdPend = 1'b1;
        end

        // A pop request stays pending until the buffer has a byte to hand over.
        if (popWanted) begin
            nxt_sys.pendPop = 1'b1;
            if (fifoOutValid) begin
                fifoOutReady = 1'b1;
                nxt_sys.holdData = fifoOutData;
                nxt_sys.popAck = !sys_ff.popAck;
                nxt_sys.pendPop = 1'b0;
            end
        end
        if (deselSync) begin
            // Mirror the link side, which sits in reset while deselected.
            nxt_sys.state = SYS_IDLE;
            nxt_sys.rdPend = 1'b0;
            nxt_sys.arrRdEn = 1'b0;
            nxt_sys.pendPop = 1'b0;
            nxt_sys.popAck = 1'b0;
            fifoOutReady = 1'b0;
        end
    end

    always_ff @(posedge clk_sys or negedge rst_b) begin
        if (!rst_b) begin
            sys_ff <= '{state: SYS_IDLE, default: '0};
        end else begin
            sys_ff <= nxt_sys;
        end
    end

    assign arrRdEn = sys_ff.arrRdEn;
    assign arrRdReg = sys_ff.arrRdReg;
    assign arrRdOffset = sys_ff.arrRdOffset;

endmodule

/* File: rtl/sfu_sync.sv */
`timescale 1ns/1ps
module sfu_sync #(
    parameter int WIDTH = 1
) (
    // Clock and reset.
    input wire logic clk,
    input wire logic rstB,
    // Asynchronous in, synchronised out.
    input wire logic [WIDTH-1:0] asyncIn,
    output logic [WIDTH-1:0] syncOut
);

    typedef struct packed {
        logic [WIDTH-1:0] stage1;
        logic [WIDTH-1:0] stage2;
    } sfu_sync_type;

    sfu_sync_type cur_ff;
    sfu_sync_type nxt_cur;

    always_comb begin
        nxt_cur.stage1 = asyncIn;
        nxt_cur.stage2 = cur_ff.stage1;
    end

    always_ff @(posedge clk or negedge rstB) begin
        if (!rstB) begin
            cur_ff <= '0;
        end else begin
            cur_ff <= nxt_cur;
        end
    end

    assign syncOut = cur_ff.stage2;

endmodule

/* File: tb/sfu_host_model.sv */
`timescale 1ns/1ps
module sfu_host_model (
    // Link outputs.
    output logic serialClk,
    output logic chipSelN,
    output logic serialInLine,
    // Link inputs.
    input wire logic serialOutData,
    input wire logic serialOutEn
);
    initial begin
        serialClk = 1'b0;
        chipSelN = 1'b1;
        serialInLine = 1'b0;
    end

    // One frame of nBits clocks; the first 40 carry the command, the rest collect data.
    task automatic frame(input logic [7:0] op, input logic [23:0] addr, input int nBits,
                         output logic [127:0] got, output logic enE, output logic enD);
        logic [39:0] cmd;
        cmd = {op, addr, ~addr[7:0]};
        got = '0;
        enE = 1'b0;
        enD = 1'b1;
        chipSelN = 1'b0;
        #32;
        for (int i = 0; i < nBits; i++) begin
            serialInLine = (i < 40) ? cmd[39 - i] : ~serialInLine;
            #32 serialClk = 1'b1;
            if (i < 40) enE |= serialOutEn;
            else got = {got[126:0], serialOutData};
            if (i >= 40) enD &= serialOutEn;
            #32 serialClk = 1'b0;
        end
        #32 chipSelN = 1'b1;
        #200;
    endtask
endmodule

/* File: tb/sfu_secreg_uid_read_assertions.sv */
`timescale 1ns/1ps
module sfu_secreg_uid_read_assertions
    import sfu_pkg::*;
(
    // System side.
    input wire logic clk_sys,
    input wire logic rst_b,
    input wire logic arrRdEn,
    input wire logic [sfu_pkg::REG_SEL_BITS-1:0] arrRdReg,
    input wire logic [sfu_pkg::BYTE_BITS-1:0] arrRdOffset,
    input wire logic [sfu_pkg::BYTE_BITS-1:0] arrRdData,
    // Link side.
    input wire logic serialClk,
    input wire logic chipSelN,
    input wire logic serialInLine,
    input wire logic serialOutData,
    input wire logic serialOutEn
);
    // ------------
    // Helper state
    // ------------
    logic [5:0] riseCnt_ff;
    logic [7:0] opcode_ff;
    logic [7:0] lastOff_ff;
    logic [1:0] lastReg_ff;
    logic [6:0] gapCnt_ff;
    logic isRead;

    assign isRead = (opcode_ff == OPC_SECREG_READ) || (opcode_ff == OPC_UID_READ);

    // Counts rising link edges of the frame and captures its opcode.
    always_ff @(posedge serialClk or posedge chipSelN) begin
        if (chipSelN) begin
            riseCnt_ff <= 6'h00;
            opcode_ff <= 8'h00;
        end else begin
            if (riseCnt_ff != 6'h3F) riseCnt_ff <= riseCnt_ff + 6'h01;
            if (riseCnt_ff < 6'h08) opcode_ff <= {opcode_ff[6:0], serialInLine};
        end
    end

    // Remembers the last array read and the cycles since it.
    always_ff @(posedge clk_sys or negedge rst_b) begin
        if (!rst_b) begin
            gapCnt_ff <= 7'h7F;
            lastOff_ff <= 8'h00;
            lastReg_ff <= 2'h0;
        end else if (arrRdEn) begin
            gapCnt_ff <= 7'h00;
            lastOff_ff <= arrRdOffset;
            lastReg_ff <= arrRdReg;
        end else if (gapCnt_ff != 7'h7F) begin
            gapCnt_ff <= gapCnt_ff + 7'h01;
        end
    end

    // ------------
    // Properties
    // ------------
    sequence readPulse;
        arrRdEn ##1 !arrRdEn;
    endsequence

    sequence selHeld;
        chipSelN [*8];
    endsequence

    AST_RD_PULSE: assert property (@(posedge clk_sys) disable iff (!rst_b)
        arrRdEn |-> readPulse) else $error("array strobe longer than one cycle");
    AST_RD_REG_LEGAL: assert property (@(posedge clk_sys) disable iff (!rst_b)
        arrRdEn |-> arrRdReg != REG_NONE) else $error("array read without a register");
    AST_RD_STEP: assert property (@(posedge clk_sys) disable iff (!rst_b)
        arrRdEn && gapCnt_ff < 7'h3C |-> arrRdOffset == lastOff_ff + 8'h01
        && arrRdReg == lastReg_ff) else $error("array offset did not step by one");
    AST_DESEL_RELEASE: assert property (@(posedge clk_sys) disable iff (!rst_b)
        chipSelN |-> !serialOutEn) else $error("output driven while deselected");
    AST_DESEL_NO_READ: assert property (@(posedge clk_sys) disable iff (!rst_b)
        selHeld |-> !arrRdEn) else $error("array read long after deselect");
    AST_IDLE_LOW: assert property (@(posedge clk_sys) disable iff (!rst_b)
        !serialOutEn |-> !serialOutData) else $error("data not low while released");
    AST_RESET_QUIET: assert property (@(posedge clk_sys) disable iff (!rst_b)
        $rose(rst_b) |-> !arrRdEn && arrRdOffset == 8'h00 && !serialOutEn)
        else $error("outputs not quiet after reset");
    AST_QUIET_CMD: assert property (@(posedge serialClk) disable iff (chipSelN || !rst_b)
        riseCnt_ff < 6'h28 |-> !serialOutEn) else $error("output before dummy end");
    AST_DATA_DRIVEN: assert property (@(posedge serialClk) disable iff (chipSelN || !rst_b)
        riseCnt_ff >= 6'h28 && isRead |-> serialOutEn) else $error("data phase not driven");
    AST_BAD_OPCODE: assert property (@(posedge serialClk) disable iff (chipSelN || !rst_b)
        riseCnt_ff >= 6'h08 && !isRead |-> !serialOutEn) else $error("unknown opcode drove out");
endmodule

bind sfu_secreg_uid_read sfu_secreg_uid_read_assertions sfu_secreg_uid_read_assertions_inst (
    .clk_sys(clk_sys), .rst_b(rst_b), .arrRdEn(arrRdEn), .arrRdReg(arrRdReg),
    .arrRdOffset(arrRdOffset), .arrRdData(arrRdData), .serialClk(serialClk),
    .chipSelN(chipSelN), .serialInLine(serialInLine), .serialOutData(serialOutData),
    .serialOutEn(serialOutEn));

/* File: tb/sfu_secreg_uid_read_tb.sv */
`timescale 1ns/1ps
module sfu_secreg_uid_read_tb;
    import sfu_pkg::*;

    // ------------
    // Wiring
    // ------------
    logic clk_sys;
    logic rst_b;
    logic serialClk;
    logic chipSelN;
    logic serialInLine;
    logic serialOutData;
    logic serialOutEn;
    logic arrRdEn;
    logic [REG_SEL_BITS-1:0] arrRdReg;
    logic [BYTE_BITS-1:0] arrRdOffset;
    logic [BYTE_BITS-1:0] arrRdData;
    int error_cnt = 0;
    int samples_checked = 0;
    int cycleCnt = 0;

    initial begin
        clk_sys = 1'b0;
        forever #12.5 clk_sys = ~clk_sys;
    end

    sfu_secreg_uid_read sfu_secreg_uid_read_inst (.clk_sys(clk_sys), .rst_b(rst_b),
        .serialClk(serialClk), .chipSelN(chipSelN), .serialInLine(serialInLine),
        .serialOutData(serialOutData), .serialOutEn(serialOutEn), .arrRdEn(arrRdEn),
        .arrRdReg(arrRdReg), .arrRdOffset(arrRdOffset), .arrRdData(arrRdData));

    sfu_host_model sfu_host_model_inst (.serialClk(serialClk), .chipSelN(chipSelN),
        .serialInLine(serialInLine), .serialOutData(serialOutData),
        .serialOutEn(serialOutEn));

    // ------------
    // Array model
    // ------------
    function automatic logic [7:0] memByte(input logic [1:0] r, input logic [7:0] o);
        return {r, 6'h00} ^ o;
    endfunction

    // Data is valid only in the cycle after the strobe and scrambled otherwise.
    always @(posedge clk_sys) begin
        if (arrRdEn) arrRdData <= memByte(arrRdReg, arrRdOffset);
        else arrRdData <= ~arrRdData;
    end

    // ------------
    // Helpers
    // ------------
    task automatic print_verdict();
        if (error_cnt == 0 && samples_checked > 0) $display("bench passed");
        else $display("bench failed");
        $finish;
    endtask

    always @(posedge clk_sys) begin
        cycleCnt++;
        if (cycleCnt == 4000) begin
            error_cnt++;
            print_verdict();
        end
    end

    task automatic check(input logic [127:0] got, input logic [127:0] exp);
        samples_checked++;
        if (got !== exp) begin
            error_cnt++;
            $display("wrong value at %0t: got %h expected %h", $time, got, exp);
        end
    endtask

    task automatic run(input logic [7:0] op, input logic [23:0] addr, input int nBits,
                       output logic [127:0] got, output logic enE, output logic enD);
        @(posedge clk_sys);
        #2;
        sfu_host_model_inst.frame(op, addr, nBits, got, enE, enD);
        check(serialOutEn, 1'b0);
    endtask

    // ------------
    // Scenarios
    // ------------
    task automatic testSecregRegs();
        logic [127:0] got;
        logic enE;
        logic enD;
        for (int r = 1; r < 4; r++) begin
            run(OPC_SECREG_READ, {8'h00, 4'(r), 4'h1, 8'h05}, 56, got, enE, enD);
            check(got[15:0], {memByte(2'(r), 8'h05), memByte(2'(r), 8'h06)});
            check({enE, enD}, 2'b01);
        end
    endtask

    task automatic testWrap();
        logic [127:0] got;
        logic enE;
        logic enD;
        run(OPC_SECREG_READ, 24'h00_31FE, 72, got, enE, enD);
        check(got[31:0], {memByte(2'h3, 8'hFE), memByte(2'h3, 8'hFF),
            memByte(2'h3, 8'h00), memByte(2'h3, 8'h01)});
    endtask

    task automatic testUndef();
        logic [127:0] got;
        logic enE;
        logic enD;
        run(OPC_SECREG_READ, 24'h01_1105, 56, got, enE, enD);
        check(got[15:0], {2{UNDEF_BYTE}});
        run(OPC_SECREG_READ, 24'h00_4105, 56, got, enE, enD);
        check(got[15:0], {2{UNDEF_BYTE}});
    endtask

    task automatic testUid();
        logic [127:0] got;
        logic enE;
        logic enD;
        run(OPC_UID_READ, 24'h00_0000, 176, got, enE, enD);
        check(got, {UID_DEFAULT[119:0], UID_DEFAULT[127:120]});
        check({enE, enD}, 2'b01);
    endtask

    task automatic testAbort();
        logic [127:0] got;
        logic enE;
        logic enD;
        run(OPC_SECREG_READ, 24'h00_1100, 43, got, enE, enD);
        check(enD, 1'b1);
        run(OPC_SECREG_READ, 24'h00_1100, 5, got, enE, enD);
        run(OPC_SECREG_READ, 24'h00_2110, 56, got, enE, enD);
        check(got[15:0], {memByte(2'h2, 8'h10), memByte(2'h2, 8'h11)});
    endtask

    task automatic testBadOpcode();
        logic [127:0] got;
        logic enE;
        logic enD;
        run(8'h03, 24'h00_1105, 56, got, enE, enD);
        check({enE, enD}, 2'b00);
    endtask

    initial begin
        rst_b = 1'b0;
        arrRdData = 8'h00;
        repeat (12) @(posedge clk_sys);
        check({arrRdEn, arrRdReg, arrRdOffset, serialOutEn, serialOutData}, 13'h0000);
        #2;
        rst_b = 1'b1;
        repeat (4) @(posedge clk_sys);
        testSecregRegs();
        testWrap();
        testUndef();
        testUid();
        testAbort();
        testBadOpcode();
        print_verdict();
    end
endmodule
